// ---- adc_seq_params.svh ----
`ifndef ADC_SEQ_PARAMS_SVH
`define ADC_SEQ_PARAMS_SVH
// Register byte offsets
`define OFS_CONV_CTL 8'h08
`define OFS_SEQ_LEN 8'h2C
`define OFS_SEQ_SLOTS 8'h34
`define OFS_RESULT 8'h4C
`define OFS_OVS_CTL 8'h80
// Reset values
`define RST_CONV_CTL 32'h0000_0000
`define RST_SEQ_LEN 32'h0000_0000
`define RST_SEQ_SLOTS 32'h0000_0000
`define RST_RESULT 32'h0000_0000
`define RST_OVS_CTL 32'h0000_0000
// Field positions
`define SLOT_W 5
`define SLOT_CNT 6
`define SEQ_SLOTS_MASK 32'h3FFF_FFFF
`define SEQ_LEN_LSB 20
`define SEQ_LEN_MASK 32'h00F0_0000
`define OVS_EN_BIT 0
`define OVS_RATIO_LSB 2
`define OVS_SHIFT_LSB 5
`define OVS_TRIG_BIT 9
`define OVS_RES_LSB 12
`define OVS_LOCKED_MASK 32'h0000_03FD
`define OVS_FREE_MASK 32'h0000_3000
`define CTL_ON_BIT 0
`define CTL_SYNC_BIT 1
`define CTL_BUSY_BIT 2
`define CTL_WR_MASK 32'h0000_0003
`define SHIFT_MAX 4'h8
`define RESULT_W 16
`define ACC_W 20
// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define RESP_DECERR 2'h3
`endif

// ---- adc_seq_pkg.sv ----
`default_nettype none
package adc_seq_pkg;
   // Conversion engine states
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_START,
      ST_WAIT_SAMPLE,
      ST_WAIT_TRIG
   } conv_state_t;

   // Oversampler settings as held in the control register
   typedef struct packed {
      logic [1:0] resultResolution;
      logic perTriggerOversampling;
      logic [3:0] oversampleShift;
      logic [2:0] oversampleRatio;
      logic oversamplerOn;
   } ovs_cfg_t;

   // Register slave channel state, one record per clock
   typedef struct packed {
      logic [7:0] awAddr;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic awHeld;
      logic wHeld;
      logic bValid;
      logic [1:0] bResp;
      logic rValid;
      logic [1:0] rResp;
      logic [31:0] rData;
   } bus_state_t;
endpackage
`default_nettype wire

// ---- adc_sequence_data_oversampler.sv ----
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "adc_seq_params.svh"
// Overview of operation
// - Five-bit slots pick channels, slot zero lowest
// - Conversion result sits in low sixteen bits
// - Sync mode shows secondary result in top half
// - Resolution field picks 12, 10, 8, 6 bits
// - Untriggered oversampling runs samples back to back
// - Triggered oversampling needs one trigger per sample, except the first sample of each slot after slot zero
// - Shift field shifts result right 0 to 8
// - Ratio field picks 2x up to 256x
// - Bit zero enables oversampler, locked while converter on
// - Sequence length is length field plus one
module adc_sequence_data_oversampler
   import adc_seq_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic conversionTrigger,
   output logic convStart,
   output logic [4:0] convChannel,
   output logic [1:0] convResolution,
   input wire logic sampleValid,
   input wire logic [11:0] sampleData,
   input wire logic secondaryValid,
   input wire logic [15:0] secondaryResult,
   output logic resultValid
);

   // Channel number held in a given slot of the slots register
   function automatic logic [4:0] slotChannel(input logic [31:0] slots, input logic [3:0] idx);
      logic [4:0] ch;
      ch = 5'h00;
      for (int i = 0; i < `SLOT_CNT; i++) begin
         if (idx == 4'(i)) begin
            ch = slots[i*`SLOT_W +: `SLOT_W];
         end
      end
      return ch;
   endfunction

   // Last sample of an oversampled group: count equals ratio samples minus one
   function automatic logic ovsLast(input logic [7:0] cnt, input logic [2:0] ratio);
      logic [8:0] total;
      total = 9'h002 << ratio;
      return {1'b0, cnt} == (total - 9'h001);
   endfunction

   // Right shift of the accumulated sum, reserved codes clamp to eight
   function automatic logic [15:0] shiftResult(input logic [19:0] acc, input logic [3:0] sh);
      logic [3:0] s;
      logic [19:0] v;
      s = (sh > `SHIFT_MAX) ? `SHIFT_MAX : sh;
      v = acc >> s;
      return v[15:0];
   endfunction

   // Trigger pin passes two flops before any use
   logic trigMeta_r, trigSync_r, trigPrev_r, trigEdge;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         trigMeta_r <= 1'b0;
         trigSync_r <= 1'b0;
         trigPrev_r <= 1'b0;
      end else begin
         trigMeta_r <= conversionTrigger;
         trigSync_r <= trigMeta_r;
         trigPrev_r <= trigSync_r;
      end
   end
   assign trigEdge = trigSync_r & ~trigPrev_r;

   // Register file and bus state
   logic [31:0] ctl_r, ctl_nxt, seqLen_r, seqLen_nxt, slots_r, slots_nxt;
   logic [31:0] ovs_r, ovs_nxt, result_r, result_nxt;
   bus_state_t bus_r, bus_nxt;
   logic doWrite, engineBusy, resPulse;
   logic [15:0] resValue;
   ovs_cfg_t cfg;

   assign cfg = ovs_cfg_t'({ovs_r[13:12], ovs_r[9:2], ovs_r[0]});
   assign s_axi_awready = ~bus_r.awHeld & ~bus_r.bValid;
   assign s_axi_wready = ~bus_r.wHeld & ~bus_r.bValid;
   assign s_axi_arready = ~bus_r.rValid;
   assign s_axi_bvalid = bus_r.bValid;
   assign s_axi_bresp = bus_r.bResp;
   assign s_axi_rvalid = bus_r.rValid;
   assign s_axi_rresp = bus_r.rResp;
   assign s_axi_rdata = bus_r.rData;
   assign doWrite = bus_r.awHeld & bus_r.wHeld;
   assign convResolution = cfg.resultResolution;

   // Next values of bus channels and registers
   always_comb begin
      bus_nxt = bus_r;
      ctl_nxt = ctl_r;
      seqLen_nxt = seqLen_r;
      slots_nxt = slots_r;
      ovs_nxt = ovs_r;
      result_nxt = result_r;
      if (s_axi_awvalid && s_axi_awready) begin
         bus_nxt.awAddr = s_axi_awaddr;
         bus_nxt.awHeld = 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         bus_nxt.wData = s_axi_wdata;
         bus_nxt.wStrb = s_axi_wstrb;
         bus_nxt.wHeld = 1'b1;
      end
      if (doWrite) begin
         bus_nxt.awHeld = 1'b0;
         bus_nxt.wHeld = 1'b0;
         bus_nxt.bValid = 1'b1;
         bus_nxt.bResp = `RESP_OKAY;
         if (bus_r.wStrb != 4'hF) begin
            bus_nxt.bResp = `RESP_SLVERR;
         end else if (bus_r.awAddr == `OFS_CONV_CTL) begin
            ctl_nxt = bus_r.wData & `CTL_WR_MASK;
         end else if (bus_r.awAddr == `OFS_SEQ_LEN) begin
            seqLen_nxt = bus_r.wData & `SEQ_LEN_MASK;
         end else if (bus_r.awAddr == `OFS_SEQ_SLOTS) begin
            slots_nxt = bus_r.wData & `SEQ_SLOTS_MASK;
         end else if (bus_r.awAddr == `OFS_OVS_CTL) begin
            // Oversampler fields except resolution hold while converter runs
            ovs_nxt = (ovs_r & ~`OVS_FREE_MASK) | (bus_r.wData & `OVS_FREE_MASK);
            if (!ctl_r[`CTL_ON_BIT]) begin
               ovs_nxt = bus_r.wData & (`OVS_FREE_MASK | `OVS_LOCKED_MASK);
            end
         end else if (bus_r.awAddr != `OFS_RESULT) begin
            bus_nxt.bResp = `RESP_DECERR;
         end
      end else if (bus_r.bValid && s_axi_bready) begin
         bus_nxt.bValid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         bus_nxt.rValid = 1'b1;
         bus_nxt.rResp = `RESP_OKAY;
         bus_nxt.rData = 32'h0000_0000;
         if (s_axi_araddr == `OFS_CONV_CTL) begin
            bus_nxt.rData = ctl_r;
            bus_nxt.rData[`CTL_BUSY_BIT] = engineBusy;
         end else if (s_axi_araddr == `OFS_SEQ_LEN) begin
            bus_nxt.rData = seqLen_r;
         end else if (s_axi_araddr == `OFS_SEQ_SLOTS) begin
            bus_nxt.rData = slots_r;
         end else if (s_axi_araddr == `OFS_RESULT) begin
            bus_nxt.rData = result_r;
         end else if (s_axi_araddr == `OFS_OVS_CTL) begin
            bus_nxt.rData = ovs_r;
         end else begin
            bus_nxt.rResp = `RESP_DECERR;
         end
      end else if (bus_r.rValid && s_axi_rready) begin
         bus_nxt.rValid = 1'b0;
      end
      // Result capture, read-only to software
      if (resPulse) begin
         result_nxt[15:0] = resValue;
      end
      if (secondaryValid && ctl_r[`CTL_SYNC_BIT]) begin
         result_nxt[31:16] = secondaryResult;
      end
   end

   // Bus and register flops
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_r <= '0; // Channels idle, OKAY response
         ctl_r <= `RST_CONV_CTL;
         seqLen_r <= `RST_SEQ_LEN;
         slots_r <= `RST_SEQ_SLOTS;
         ovs_r <= `RST_OVS_CTL;
         result_r <= `RST_RESULT;
      end else begin
         bus_r <= bus_nxt;
         ctl_r <= ctl_nxt;
         seqLen_r <= seqLen_nxt;
         slots_r <= slots_nxt;
         ovs_r <= ovs_nxt;
         result_r <= result_nxt;
      end
   end

   // Conversion engine state
   conv_state_t state_r, state_nxt;
   logic [3:0] slot_r, slot_nxt, seqLast;
   logic [7:0] cnt_r, cnt_nxt;
   logic [19:0] acc_r, acc_nxt, accSum;
   logic [4:0] chan_r, chan_nxt;
   logic resPulse_r, resPulse_nxt;
   logic [15:0] resValue_r, resValue_nxt;

   assign seqLast = seqLen_r[`SEQ_LEN_LSB +: 4];
   assign accSum = acc_r + {8'h00, sampleData};
   assign engineBusy = (state_r != ST_IDLE);
   assign convStart = (state_r == ST_START);
   assign convChannel = chan_r;
   assign resPulse = resPulse_r;
   assign resValue = resValue_r;
   assign resultValid = resPulse_r;

   // Sequence stepping, oversampling and triggering
   always_comb begin
      state_nxt = state_r;
      slot_nxt = slot_r;
      cnt_nxt = cnt_r;
      acc_nxt = acc_r;
      chan_nxt = chan_r;
      resPulse_nxt = 1'b0;
      resValue_nxt = resValue_r;
      case (state_r)
         ST_IDLE: begin
            if (ctl_r[`CTL_ON_BIT] && trigEdge) begin
               slot_nxt = 4'h0;
               cnt_nxt = 8'h00;
               acc_nxt = 20'h00000;
               chan_nxt = slotChannel(slots_r, 4'h0);
               state_nxt = ST_START;
            end
         end
         ST_START: begin
            state_nxt = ST_WAIT_SAMPLE;
         end
         ST_WAIT_SAMPLE: begin
            if (sampleValid) begin
               if (cfg.oversamplerOn && !ovsLast(cnt_r, cfg.oversampleRatio)) begin
                  acc_nxt = accSum;
                  cnt_nxt = cnt_r + 8'h01;
                  state_nxt = cfg.perTriggerOversampling ? ST_WAIT_TRIG : ST_START;
               end else begin
                  resPulse_nxt = 1'b1;
                  resValue_nxt = cfg.oversamplerOn ?
                     shiftResult(accSum, cfg.oversampleShift) : {4'h0, sampleData};
                  acc_nxt = 20'h00000;
                  cnt_nxt = 8'h00;
                  if (slot_r == seqLast) begin
                     state_nxt = ST_IDLE;
                  end else begin
                     slot_nxt = slot_r + 4'h1;
                     chan_nxt = slotChannel(slots_r, slot_r + 4'h1);
                     state_nxt = ST_START;
                  end
               end
            end
         end
         ST_WAIT_TRIG: begin
            if (trigEdge) begin
               state_nxt = ST_START;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
      if (!ctl_r[`CTL_ON_BIT]) begin
         state_nxt = ST_IDLE;
      end
   end

   // Engine flops
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
         slot_r <= 4'h0;
         cnt_r <= 8'h00;
         acc_r <= 20'h00000;
         chan_r <= 5'h00;
         resPulse_r <= 1'b0;
         resValue_r <= 16'h0000;
      end else begin
         state_r <= state_nxt;
         slot_r <= slot_nxt;
         cnt_r <= cnt_nxt;
         acc_r <= acc_nxt;
         chan_r <= chan_nxt;
         resPulse_r <= resPulse_nxt;
         resValue_r <= resValue_nxt;
      end
   end

   // Checks on the engine and registers
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   chk_result_low: assert property (resPulse_r |=> result_r[15:0] == $past(resValue_r))
      else $error("result low half not updated");
   chk_sync_upper: assert property (secondaryValid && ctl_r[1] |=>
      result_r[31:16] == $past(secondaryResult)) else $error("secondary result not shown");
   chk_resolution_out: assert property (doWrite && bus_r.awAddr == `OFS_OVS_CTL &&
      bus_r.wStrb == 4'hF |=> convResolution == $past(bus_r.wData[13:12]))
      else $error("resolution not taken from write");
   chk_no_trig_wait: assert property (!ovs_r[9] && state_r == ST_WAIT_SAMPLE &&
      sampleValid && !resPulse_nxt && ctl_r[0] |=> state_r == ST_START)
      else $error("untriggered oversampling stalled");
   chk_trig_wait: assert property (ovs_r[9] && state_r == ST_WAIT_SAMPLE &&
      sampleValid && !resPulse_nxt && ctl_r[0] |=> state_r == ST_WAIT_TRIG)
      else $error("triggered oversampling did not wait");
   chk_ovs_locked: assert property (ctl_r[0] && $past(ctl_r[0]) |-> $stable(ovs_r[9:0]))
      else $error("oversampler settings changed while on");
   chk_seq_order: assert property (resPulse_nxt && state_nxt == ST_START |=>
      slot_r == $past(slot_r) + 4'h1) else $error("slot order broken");
   chk_seq_end: assert property (resPulse_nxt && slot_r == seqLast && ctl_r[0] |=>
      state_r == ST_IDLE) else $error("sequence did not end at length");
   chk_chan_slot: assert property (state_r == ST_START |->
      chan_r == slotChannel(slots_r, slot_r)) else $error("channel does not match slot");

   cov_ovs_done: cover property (resPulse_r && ovs_r[0]);
   cov_trig_ovs: cover property (state_r == ST_WAIT_TRIG ##[1:50] state_r == ST_START);
   cov_full_seq: cover property (resPulse_r && state_r == ST_IDLE && slot_r != 4'h0);

endmodule // adc_sequence_data_oversampler
`default_nettype wire

// ---- adc_sequence_data_oversampler_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "adc_seq_params.svh"
module adc_sequence_data_oversampler_tb
   import adc_seq_pkg::*;
;
   logic sys_clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, convResolution;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic conversionTrigger, convStart, sampleValid, secondaryValid, resultValid;
   logic [4:0] convChannel;
   logic [11:0] sampleData;
   logic [15:0] secondaryResult;
   int n_fail, num_checks, n;

   adc_sequence_data_oversampler uut (
      .sys_clk(sys_clk), .rst_n(rst_n),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .conversionTrigger(conversionTrigger), .convStart(convStart), .convChannel(convChannel),
      .convResolution(convResolution), .sampleValid(sampleValid), .sampleData(sampleData),
      .secondaryValid(secondaryValid), .secondaryResult(secondaryResult),
      .resultValid(resultValid)
   );

   // Verdict and end of run
   task automatic report_and_stop();
      $display("Checks %0d, mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // Value comparison
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic timeout();
      n_fail++;
      $display("MISMATCH at %0t: wait limit reached", $time);
      report_and_stop();
   endtask

   // Register write; handshakes judged from values settled before each edge
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
      input logic [1:0] er);
      logic aT, wT, bT;
      logic [1:0] rsp;
      bT = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      for (int i = 0; i < 40 && !bT; i++) begin
         @(negedge sys_clk);
         aT = s_axi_awvalid & s_axi_awready;
         wT = s_axi_wvalid & s_axi_wready;
         bT = (s_axi_bvalid === 1'b1);
         rsp = s_axi_bresp;
         @(posedge sys_clk);
         if (aT) s_axi_awvalid <= 1'b0;
         if (wT) s_axi_wvalid <= 1'b0;
      end
      if (!bT) timeout();
      chk({30'h0, rsp}, {30'h0, er});
   endtask

   // Register read
   task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic aT, rT;
      logic [31:0] d;
      logic [1:0] rsp;
      rT = 1'b0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      for (int i = 0; i < 40 && !rT; i++) begin
         @(negedge sys_clk);
         aT = s_axi_arvalid & s_axi_arready;
         rT = (s_axi_rvalid === 1'b1);
         d = s_axi_rdata;
         rsp = s_axi_rresp;
         @(posedge sys_clk);
         if (aT) s_axi_arvalid <= 1'b0;
      end
      if (!rT) timeout();
      chk(d, ed);
      chk({30'h0, rsp}, {30'h0, er});
   endtask

   // Wait for a conversion start and check its channel
   task automatic wait_start(input logic [4:0] ch);
      logic seen;
      seen = 1'b0;
      for (int i = 0; i < 40 && !seen; i++) begin
         @(negedge sys_clk);
         seen = (convStart === 1'b1);
         if (!seen) @(posedge sys_clk);
      end
      if (!seen) timeout();
      chk({27'h0, convChannel}, {27'h0, ch});
      @(posedge sys_clk);
   endtask

   // Trigger pin pulse held until the start appears
   task automatic trig_start(input logic [4:0] ch);
      repeat (3) @(posedge sys_clk);
      conversionTrigger <= 1'b1;
      wait_start(ch);
      conversionTrigger <= 1'b0;
   endtask

   // One sample; then result pulse and the following start are checked
   task automatic sample(input logic [11:0] d, input logic rv, input logic st,
      input logic [4:0] ch);
      sampleData <= d;
      sampleValid <= 1'b1;
      @(posedge sys_clk);
      sampleValid <= 1'b0;
      @(negedge sys_clk);
      chk({31'h0, resultValid}, {31'h0, rv});
      chk({31'h0, convStart}, {31'h0, st});
      if (st) chk({27'h0, convChannel}, {27'h0, ch});
      @(posedge sys_clk);
   endtask

   task automatic secondary(input logic [15:0] d);
      secondaryResult <= d;
      secondaryValid <= 1'b1;
      @(posedge sys_clk);
      secondaryValid <= 1'b0;
      @(posedge sys_clk);
   endtask

   // Oversampler set up with the converter off, then switched on
   task automatic cfg(input logic [31:0] v);
      axi_write(`OFS_CONV_CTL, 32'h0, 4'hF, `RESP_OKAY);
      axi_write(`OFS_OVS_CTL, v, 4'hF, `RESP_OKAY);
      axi_write(`OFS_CONV_CTL, 32'h1, 4'hF, `RESP_OKAY);
   endtask

   // Clock
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   // Main sequence
   initial begin
      n_fail = 0;
      num_checks = 0;
      rst_n = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
      {s_axi_bready, s_axi_rready} = 2'h3;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hF;
      {conversionTrigger, sampleValid, secondaryValid} = 3'h0;
      sampleData = 12'h000;
      secondaryResult = 16'h0000;
      repeat (4) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      axi_read(`OFS_SEQ_SLOTS, `RST_SEQ_SLOTS, `RESP_OKAY);
      axi_read(`OFS_RESULT, `RST_RESULT, `RESP_OKAY);
      axi_read(`OFS_OVS_CTL, `RST_OVS_CTL, `RESP_OKAY);
      axi_write(`OFS_SEQ_SLOTS, 32'hFFFF_FFFF, 4'hF, `RESP_OKAY);
      axi_read(`OFS_SEQ_SLOTS, 32'h3FFF_FFFF, `RESP_OKAY);
      axi_write(`OFS_SEQ_SLOTS, 32'h1400_1623, 4'h3, `RESP_SLVERR);
      axi_read(`OFS_SEQ_SLOTS, 32'h3FFF_FFFF, `RESP_OKAY);
      axi_write(`OFS_SEQ_SLOTS, 32'h1400_1623, 4'hF, `RESP_OKAY);
      axi_read(`OFS_SEQ_SLOTS, 32'h1400_1623, `RESP_OKAY);
      axi_write(`OFS_RESULT, 32'hFFFF_FFFF, 4'hF, `RESP_OKAY);
      axi_read(`OFS_RESULT, 32'h0000_0000, `RESP_OKAY);
      axi_read(8'h10, 32'h0000_0000, `RESP_DECERR);
      axi_write(8'h10, 32'h0000_0001, 4'hF, `RESP_DECERR);
      axi_write(`OFS_OVS_CTL, 32'hFFFF_FFFF, 4'hF, `RESP_OKAY);
      axi_read(`OFS_OVS_CTL, 32'h0000_33FD, `RESP_OKAY);
      // Every resolution code reaches the converter
      for (int r = 0; r < 4; r++) begin
         axi_write(`OFS_OVS_CTL, {18'h0, r[1:0], 12'h0}, 4'hF, `RESP_OKAY);
         chk({30'h0, convResolution}, {30'h0, r[1:0]});
      end
      // Three-slot pass in sync mode, oversampler off
      axi_write(`OFS_OVS_CTL, 32'h0, 4'hF, `RESP_OKAY);
      axi_write(`OFS_SEQ_LEN, 32'hFFFF_FFFF, 4'hF, `RESP_OKAY);
      axi_read(`OFS_SEQ_LEN, 32'h00F0_0000, `RESP_OKAY);
      axi_write(`OFS_SEQ_LEN, 32'h0020_0000, 4'hF, `RESP_OKAY);
      axi_write(`OFS_CONV_CTL, 32'h3, 4'hF, `RESP_OKAY);
      trig_start(5'h03);
      // Control reads back on, sync and busy while a sample is awaited
      axi_read(`OFS_CONV_CTL, 32'h0000_0007, `RESP_OKAY);
      sample(12'hABC, 1'b1, 1'b1, 5'h11);
      secondary(16'h1234);
      sample(12'h001, 1'b1, 1'b1, 5'h05);
      sample(12'hFFF, 1'b1, 1'b0, 5'h00);
      axi_read(`OFS_RESULT, 32'h1234_0FFF, `RESP_OKAY);
      axi_write(`OFS_OVS_CTL, 32'h0000_13FD, 4'hF, `RESP_OKAY);
      axi_read(`OFS_OVS_CTL, 32'h0000_1000, `RESP_OKAY);
      axi_write(`OFS_CONV_CTL, 32'h1, 4'hF, `RESP_OKAY);
      secondary(16'h5555);
      axi_read(`OFS_RESULT, 32'h1234_0FFF, `RESP_OKAY);
      // Each ratio with a matching shift, samples back to back
      axi_write(`OFS_SEQ_LEN, 32'h0, 4'hF, `RESP_OKAY);
      for (int r = 0; r < 8; r++) begin
         cfg((r << 5) | (r << 2) | 1);
         n = 2 << r;
         trig_start(5'h03);
         for (int k = 0; k < n; k++) sample(12'hFFF, k == n - 1, k != n - 1, 5'h03);
         axi_read(`OFS_RESULT, 32'h1234_1FFE, `RESP_OKAY);
      end
      // Triggered oversampling, 4x, shift by eight
      cfg(32'h0000_0305);
      for (int k = 0; k < 4; k++) begin
         trig_start(5'h03);
         sample(12'hFFF, k == 3, 1'b0, 5'h00);
      end
      axi_read(`OFS_RESULT, 32'h1234_003F, `RESP_OKAY);
      report_and_stop();
   end
endmodule // adc_sequence_data_oversampler_tb
`default_nettype wire
